/* rtl/cfg_access_pkg.sv */
// package: constants shared by the configuration access unit and its host
// assumes: both ends on one clock, byte-wide i/o port cycles
package cfg_access_pkg;
    // ----------------------------------------------------------------
    // port addresses and key bytes
    // ----------------------------------------------------------------
    localparam logic [15:0] PORT_PAIR_LOW = 16'h002e;  // strap low pair
    localparam logic [15:0] PORT_PAIR_HIGH = 16'h004e; // strap high pair
    localparam logic [7:0] UNLOCK_KEY = 8'h87;          // enter key
    localparam logic [7:0] LOCK_KEY = 8'haa;            // exit key
    // ----------------------------------------------------------------
    // global register indices
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_SOFT_RESET = 8'h02;
    localparam logic [7:0] IDX_FUNC_SEL = 8'h07;
    localparam logic [7:0] IDX_ID_HIGH = 8'h20;
    localparam logic [7:0] IDX_ID_LOW = 8'h21;
    localparam logic [7:0] IDX_PD_A = 8'h22;
    localparam logic [7:0] IDX_PD_B = 8'h23;
    localparam logic [7:0] IDX_OPT_A = 8'h24;
    localparam logic [7:0] IDX_TRISTATE = 8'h25;
    localparam logic [7:0] IDX_OPT_B = 8'h26;
    localparam logic [7:0] IDX_RSVD_27 = 8'h27;
    localparam logic [7:0] IDX_OPT_C = 8'h28;
    localparam logic [7:0] IDX_PINSEL_A = 8'h29;
    localparam logic [7:0] IDX_SBUS_SEL = 8'h2a;
    localparam logic [7:0] IDX_RSVD_2B = 8'h2b;
    localparam logic [7:0] IDX_PINSEL_B = 8'h2c;
    localparam logic [7:0] IDX_GPIO2_DET = 8'h2d;
    localparam logic [7:0] IDX_RSVD_2E = 8'h2e;
    localparam logic [7:0] IDX_RSVD_2F = 8'h2f;
    localparam logic [7:0] IDX_FUNC_BASE = 8'h30;  // first per-function index
    // ----------------------------------------------------------------
    // reset values and strap fields
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_FUNC_SEL = 8'h00;
    localparam logic [7:0] RST_PD_A = 8'hff;
    localparam logic [7:0] RST_PD_B = 8'hf0;
    localparam logic [7:0] RST_OPT_A = 8'h40;  // strapped bits 2:1 at zero
    localparam logic [7:0] RST_OPT_B = 8'h00;  // strapped bit 6 at zero
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PINSEL_B = 8'h02;
    localparam int OPT_A_FDC_BIT = 1;   // floppy enable strap
    localparam int OPT_A_KBC_BIT = 2;   // keyboard enable strap
    localparam int OPT_B_PAIR_BIT = 6;  // port pair strap
    localparam logic [3:0] FUNC_RESERVED = 4'h4;   // unused function number
    localparam int FUNC_COUNT = 16;
    localparam int FUNC_REGS = 208;                // indices 30h..ffh
    // ----------------------------------------------------------------
    // host command register map (avalon word offsets as bytes)
    // ----------------------------------------------------------------
    localparam logic [3:0] HOST_CMD_OFS = 4'h0;    // w: op, index, data
    localparam logic [3:0] HOST_STATUS_OFS = 4'h4; // r: busy, last data
    localparam int CMD_OP_LSB = 16;                // op field bits 17:16
    localparam int CMD_IDX_LSB = 8;                // index bits 15:8
    localparam logic [1:0] OP_ENTER = 2'h0;
    localparam logic [1:0] OP_EXIT = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [7:0] PORT_DATA_OFS = 8'h01;  // data port above index
endpackage

/* rtl/cfg_port_if.sv */
// interface: byte i/o port cycles between host controller and device
// assumes: one clock, single-cycle strobes, read data registered
`timescale 1ns/1ps
interface cfg_port_if;
    logic [15:0] io_addr;   // i/o port address
    logic [7:0] io_wdata;   // write byte
    logic io_wr;            // one-cycle write strobe
    logic io_rd;            // one-cycle read strobe
    logic [7:0] io_rdata;   // read byte, valid the cycle after io_rd
    modport dev (input io_addr, io_wdata, io_wr, io_rd, output io_rdata);
    modport host (output io_addr, io_wdata, io_wr, io_rd, input io_rdata);
endinterface

/* rtl/cfg_function_bank.sv */
// file: per-function register storage at indices 30h upward
// assumes: caller qualifies writes with configuration mode
`timescale 1ns/1ps
module cfg_function_bank (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] func_sel,
    input wire logic [7:0] index,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] mem [cfg_access_pkg::FUNC_COUNT*cfg_access_pkg::FUNC_REGS];
    logic [11:0] addr; // flat address of func/index
    logic valid_fn;    // function number in use

    always_comb begin
        addr = 12'(func_sel) * 12'(cfg_access_pkg::FUNC_REGS)
             + 12'(index - cfg_access_pkg::IDX_FUNC_BASE);
        valid_fn = (func_sel != cfg_access_pkg::FUNC_RESERVED);
    end

    // write port; reserved function holds nothing
    always_ff @(posedge clk) begin
        if (wr_en && valid_fn) begin
            mem[addr] <= wdata;
        end
    end

    // reads of the reserved function give zero
    always_comb begin
        rdata = valid_fn ? mem[addr] : cfg_access_pkg::RST_ZERO;
    end
endmodule

/* rtl/cfg_access_dev.sv */
// file: configuration access unit, device end of the port pair
// assumes: host keeps unlock/select order; strap pins are outside levels
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
module cfg_access_dev #(
    parameter logic [7:0] ID_HIGH = 8'h5a, // arbitrary identity value
    parameter logic [3:0] ID_LOW_TOP = 4'h6, // arbitrary identity value
    parameter logic [3:0] ID_REV = 4'h1    // arbitrary identity value
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    cfg_port_if.dev BUS,
    input wire logic PAIR_STRAP_PIN,
    input wire logic FDC_STRAP_PIN,
    input wire logic KBC_STRAP_PIN,
    output logic CONFIG_MODE,
    output logic [15:0] FUNC_ACTIVE,
    output logic SOFT_RESET_PULSE
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [2:0] strap_s1_reg, strap_s2_reg; // pin synchronisers
    logic strap_done_reg;                   // straps captured once
    logic key_seen_reg;                     // first unlock byte seen
    logic cfg_mode_reg;                     // configuration mode
    logic [7:0] index_reg;                  // current register index
    logic [7:0] func_sel_reg;               // function_select
    logic [7:0] pd_a_reg, pd_b_reg, opt_a_reg, tri_reg, opt_b_reg;
    logic [7:0] opt_c_reg, pin_a_reg, sbus_reg, pin_b_reg, det_reg;
    logic [7:0] rsvd_2e_reg, rsvd_2f_reg;
    logic [7:0] rdata_reg;                  // read answer
    logic soft_rst_reg;                     // soft reset pulse
    logic [15:0] fn_act_reg;                // decoded function enables
    logic [15:0] base;                      // selected pair base
    logic hit_idx, hit_dat, wr_idx, wr_dat; // port decode
    logic glob_wr;                          // global register write
    logic [7:0] glob_rd, fn_rd;             // read sources

    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    // two-flop synchronise pin levels; kept free of reset so that the
    // second flop already holds settled pin levels when reset lifts
    always_ff @(posedge CLK_SYS) begin
        strap_s1_reg <= {PAIR_STRAP_PIN, FDC_STRAP_PIN, KBC_STRAP_PIN};
        strap_s2_reg <= strap_s1_reg;
    end

    // ----------------------------------------------------------------
    // port decode
    // ----------------------------------------------------------------
    always_comb begin
        base = opt_b_reg[cfg_access_pkg::OPT_B_PAIR_BIT]
             ? cfg_access_pkg::PORT_PAIR_HIGH
             : cfg_access_pkg::PORT_PAIR_LOW;
        hit_idx = (BUS.io_addr == base);
        hit_dat = (BUS.io_addr == base + 16'(cfg_access_pkg::PORT_DATA_OFS));
        wr_idx = BUS.io_wr && hit_idx;
        wr_dat = BUS.io_wr && hit_dat && cfg_mode_reg;
        glob_wr = wr_dat && (index_reg < cfg_access_pkg::IDX_FUNC_BASE);
    end

    // ----------------------------------------------------------------
    // mode sequencing
    // ----------------------------------------------------------------
    // unlock needs two back-to-back key writes; any other write to the port pair breaks it
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            key_seen_reg <= 1'b0;
            cfg_mode_reg <= 1'b0;
        end else if (BUS.io_wr && (hit_idx || hit_dat)) begin
            if (!cfg_mode_reg) begin
                // not configured: only key bytes count
                if (wr_idx && BUS.io_wdata == cfg_access_pkg::UNLOCK_KEY) begin
                    key_seen_reg <= !key_seen_reg;
                    cfg_mode_reg <= key_seen_reg;
                end else begin
                    key_seen_reg <= 1'b0;
                end
            end else if (wr_idx && BUS.io_wdata == cfg_access_pkg::LOCK_KEY) begin
                cfg_mode_reg <= 1'b0;
                key_seen_reg <= 1'b0;
            end
        end
    end

    // index latch in configuration mode
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            index_reg <= cfg_access_pkg::RST_ZERO;
        end else if (wr_idx && cfg_mode_reg
                     && BUS.io_wdata != cfg_access_pkg::LOCK_KEY) begin
            index_reg <= BUS.io_wdata;
        end
    end

    // ----------------------------------------------------------------
    // global registers
    // ----------------------------------------------------------------
    // writable globals, reachable whatever function is chosen
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            func_sel_reg <= cfg_access_pkg::RST_FUNC_SEL;
            pd_a_reg <= cfg_access_pkg::RST_PD_A;
            pd_b_reg <= cfg_access_pkg::RST_PD_B;
            tri_reg <= cfg_access_pkg::RST_ZERO;
            opt_c_reg <= cfg_access_pkg::RST_ZERO;
            pin_a_reg <= cfg_access_pkg::RST_ZERO;
            sbus_reg <= cfg_access_pkg::RST_ZERO;
            pin_b_reg <= cfg_access_pkg::RST_PINSEL_B;
            det_reg <= cfg_access_pkg::RST_ZERO;
            rsvd_2e_reg <= cfg_access_pkg::RST_ZERO;
            rsvd_2f_reg <= cfg_access_pkg::RST_ZERO;
        end else if (glob_wr) begin
            case (index_reg)
                cfg_access_pkg::IDX_FUNC_SEL: begin
                    func_sel_reg <= BUS.io_wdata;
                end
                cfg_access_pkg::IDX_PD_A: pd_a_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_PD_B: pd_b_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_TRISTATE: tri_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_OPT_C: opt_c_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_PINSEL_A: pin_a_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_SBUS_SEL: sbus_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_PINSEL_B: pin_b_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_GPIO2_DET: det_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_RSVD_2E: rsvd_2e_reg <= BUS.io_wdata;
                cfg_access_pkg::IDX_RSVD_2F: rsvd_2f_reg <= BUS.io_wdata;
                default: ;
            endcase
        end
    end

    // option registers with strapped bits, loaded after reset release
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            strap_done_reg <= 1'b0;
            opt_a_reg <= cfg_access_pkg::RST_OPT_A;
            opt_b_reg <= cfg_access_pkg::RST_OPT_B;
        end else if (!strap_done_reg) begin
            // synchroniser ran through reset, so its levels are settled
            strap_done_reg <= 1'b1;
            opt_a_reg[cfg_access_pkg::OPT_A_FDC_BIT] <= strap_s2_reg[1];
            opt_a_reg[cfg_access_pkg::OPT_A_KBC_BIT] <= strap_s2_reg[0];
            opt_b_reg[cfg_access_pkg::OPT_B_PAIR_BIT] <= strap_s2_reg[2];
        end else if (glob_wr && index_reg == cfg_access_pkg::IDX_OPT_A) begin
            opt_a_reg <= BUS.io_wdata;
        end else if (glob_wr && index_reg == cfg_access_pkg::IDX_OPT_B) begin
            opt_b_reg <= BUS.io_wdata;
        end
    end

    // soft reset write gives a one-cycle pulse
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= glob_wr
                && index_reg == cfg_access_pkg::IDX_SOFT_RESET;
        end
    end

    // ----------------------------------------------------------------
    // function bank
    // ----------------------------------------------------------------
    cfg_function_bank u_bank (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .func_sel(func_sel_reg[3:0]),
        .index(index_reg),
        .wr_en(wr_dat && index_reg >= cfg_access_pkg::IDX_FUNC_BASE),
        .wdata(BUS.io_wdata),
        .rdata(fn_rd)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        case (index_reg)
            cfg_access_pkg::IDX_FUNC_SEL: glob_rd = func_sel_reg;
            cfg_access_pkg::IDX_ID_HIGH: glob_rd = ID_HIGH;
            cfg_access_pkg::IDX_ID_LOW: glob_rd = {ID_LOW_TOP, ID_REV};
            cfg_access_pkg::IDX_PD_A: glob_rd = pd_a_reg;
            cfg_access_pkg::IDX_PD_B: glob_rd = pd_b_reg;
            cfg_access_pkg::IDX_OPT_A: glob_rd = opt_a_reg;
            cfg_access_pkg::IDX_TRISTATE: glob_rd = tri_reg;
            cfg_access_pkg::IDX_OPT_B: glob_rd = opt_b_reg;
            cfg_access_pkg::IDX_OPT_C: glob_rd = opt_c_reg;
            cfg_access_pkg::IDX_PINSEL_A: glob_rd = pin_a_reg;
            cfg_access_pkg::IDX_SBUS_SEL: glob_rd = sbus_reg;
            cfg_access_pkg::IDX_PINSEL_B: glob_rd = pin_b_reg;
            cfg_access_pkg::IDX_GPIO2_DET: glob_rd = det_reg;
            cfg_access_pkg::IDX_RSVD_2E: glob_rd = rsvd_2e_reg;
            cfg_access_pkg::IDX_RSVD_2F: glob_rd = rsvd_2f_reg;
            default: glob_rd = cfg_access_pkg::RST_ZERO; // reserved read zero
        endcase
    end

    // registered answer: data port or index port in config mode, else zero
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rdata_reg <= cfg_access_pkg::RST_ZERO;
        end else if (BUS.io_rd && hit_dat && cfg_mode_reg) begin
            rdata_reg <= (index_reg < cfg_access_pkg::IDX_FUNC_BASE)
                       ? glob_rd : fn_rd;
        end else if (BUS.io_rd && hit_idx && cfg_mode_reg) begin
            rdata_reg <= index_reg;
        end else if (BUS.io_rd) begin
            rdata_reg <= cfg_access_pkg::RST_ZERO;
        end
    end
    assign BUS.io_rdata = rdata_reg;

    // one-hot enable of the chosen function; 4 and >F give none
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            fn_act_reg <= 16'h0001;
        end else if (func_sel_reg[7:4] != 4'h0
                     || func_sel_reg[3:0] == cfg_access_pkg::FUNC_RESERVED) begin
            fn_act_reg <= 16'h0000;
        end else begin
            fn_act_reg <= 16'h0001 << func_sel_reg[3:0];
        end
    end

    assign CONFIG_MODE = cfg_mode_reg;
    assign FUNC_ACTIVE = fn_act_reg;
    assign SOFT_RESET_PULSE = soft_rst_reg;
endmodule

/* rtl/cfg_access_host.sv */
// file: host end; turns avalon-mm commands into port cycles
// assumes: device answers a read strobe on the next cycle
`timescale 1ns/1ps
module cfg_access_host (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic PAIR_HIGH,
    cfg_port_if.host BUS
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum {S_IDLE, S_KEY2, S_IDX, S_DATA, S_RWAIT, S_ACK} st_t;
    st_t st_reg;
    logic [1:0] op_reg;        // command op
    logic [7:0] dat_reg, last_reg;
    logic busy_reg, wait_reg;
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg;
    logic wr_reg, rd_reg;
    logic [31:0] rd_reg_out;
    logic pair_s1, pair_s2;    // strap level synchroniser
    logic [15:0] base;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pair_s1 <= 1'b0;
            pair_s2 <= 1'b0;
        end else begin
            pair_s1 <= PAIR_HIGH;
            pair_s2 <= pair_s1;
        end
    end
    assign base = pair_s2 ? cfg_access_pkg::PORT_PAIR_HIGH
                          : cfg_access_pkg::PORT_PAIR_LOW;

    // avalon slave: command write starts sequence, status read immediate
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            st_reg <= S_IDLE;
            op_reg <= cfg_access_pkg::OP_ENTER;
            dat_reg <= 8'h00;
            last_reg <= 8'h00;
            busy_reg <= 1'b0;
            wait_reg <= 1'b1;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            rd_reg_out <= 32'h0;
        end else begin
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            wait_reg <= 1'b1;
            case (st_reg)
                S_IDLE: begin
                    if (AVS_WRITE && AVS_ADDRESS == cfg_access_pkg::HOST_CMD_OFS)
                    begin
                        op_reg <= AVS_WRITEDATA[cfg_access_pkg::CMD_OP_LSB +: 2];
                        dat_reg <= AVS_WRITEDATA[7:0];
                        busy_reg <= 1'b1;
                        addr_reg <= base;
                        wr_reg <= 1'b1;
                        case (AVS_WRITEDATA[cfg_access_pkg::CMD_OP_LSB +: 2])
                            cfg_access_pkg::OP_ENTER: begin
                                wdata_reg <= cfg_access_pkg::UNLOCK_KEY;
                                st_reg <= S_KEY2;
                            end
                            cfg_access_pkg::OP_EXIT: begin
                                wdata_reg <= cfg_access_pkg::LOCK_KEY;
                                st_reg <= S_ACK;
                            end
                            default: begin
                                // index first, then data port
                                wdata_reg <=
                                    AVS_WRITEDATA[cfg_access_pkg::CMD_IDX_LSB +: 8];
                                st_reg <= S_IDX;
                            end
                        endcase
                    end else if (AVS_READ || AVS_WRITE) begin
                        wait_reg <= 1'b0;
                        rd_reg_out <= (AVS_ADDRESS
                            == cfg_access_pkg::HOST_STATUS_OFS)
                            ? {23'h0, busy_reg, last_reg} : 32'h0;
                        st_reg <= S_ACK;
                    end
                end
                S_KEY2: begin
                    wr_reg <= 1'b1;  // second key back to back
                    wdata_reg <= cfg_access_pkg::UNLOCK_KEY;
                    st_reg <= S_ACK;
                end
                S_IDX: begin
                    addr_reg <= base + 16'(cfg_access_pkg::PORT_DATA_OFS);
                    if (op_reg == cfg_access_pkg::OP_WRITE) begin
                        wr_reg <= 1'b1;
                        wdata_reg <= dat_reg;
                        st_reg <= S_ACK;
                    end else begin
                        rd_reg <= 1'b1;
                        st_reg <= S_RWAIT;
                    end
                end
                S_RWAIT: begin
                    st_reg <= S_DATA;
                end
                S_DATA: begin
                    last_reg <= BUS.io_rdata;
                    st_reg <= S_ACK;
                end
                S_ACK: begin
                    // release waitrequest, then stay here over the
                    // completion edge so the still-held command write
                    // is not taken again as a new command
                    if (busy_reg) begin
                        busy_reg <= 1'b0;
                        wait_reg <= 1'b0;
                    end else begin
                        st_reg <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    assign AVS_READDATA = rd_reg_out;
    assign AVS_WAITREQUEST = wait_reg;
    assign BUS.io_addr = addr_reg;
    assign BUS.io_wdata = wdata_reg;
    assign BUS.io_wr = wr_reg;
    assign BUS.io_rd = rd_reg;
endmodule

/* verif/cfg_port_checker.sv */
// checker: port-link timing between host end and device end
// assumes: instantiated in tb_top beside the joining interface
`timescale 1ns/1ps
module cfg_port_checker (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic CONFIG_MODE,
    input wire logic [15:0] FUNC_ACTIVE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    // one unlock byte at the index port
    sequence key_s;
        io_wr && !io_addr[0] && io_wdata == 8'h87;
    endsequence
    a_no_overlap: assert property (!(io_wr && io_rd))
        else $error("read and write strobes overlap");
    a_port_pair: assert property (io_wr |->
        io_addr[15:1] == 15'h17 || io_addr[15:1] == 15'h27)
        else $error("write outside the port pair");
    a_key_enter: assert property (!CONFIG_MODE ##0 key_s ##1 key_s
        |=> CONFIG_MODE) else $error("double key did not unlock");
    a_lock_key: assert property (CONFIG_MODE && io_wr
        && !io_addr[0] && io_wdata == 8'haa |=> !CONFIG_MODE)
        else $error("lock ignored");
    a_stay_locked: assert property (!CONFIG_MODE && !io_wr
        |=> !CONFIG_MODE) else $error("unlocked without key");
    a_data_locked: assert property (!CONFIG_MODE && io_wr
        && io_addr[0] |=> !CONFIG_MODE) else $error("data write unlocked");
    a_read_locked: assert property (!CONFIG_MODE && io_rd
        && io_addr[0] |=> io_rdata == 8'h00) else $error("locked read");
    a_func_map: assert property ($onehot0(FUNC_ACTIVE)
        && !FUNC_ACTIVE[4]) else $error("function enables not one-hot");
    a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read byte changed without read");
endmodule

/* verif/tb_top.sv */
// testbench: avalon commands through host end into device end
// assumes: design files compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    mismatches++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_top;
    logic clk = 0, rstn = 0, strap = 0, rd = 0, wr = 0, wq, cfg, sr;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdq, q;
    logic [15:0] fa;
    int mismatches = 0, total_checks = 0, i;
    int pulses = 0; // soft reset pulses seen
    cfg_port_if bus_if ();
    cfg_access_dev cfg_access_dev_i (.CLK_SYS(clk), .RESETN(rstn),
        .BUS(bus_if), .PAIR_STRAP_PIN(strap), .FDC_STRAP_PIN(strap),
        .KBC_STRAP_PIN(strap), .CONFIG_MODE(cfg), .FUNC_ACTIVE(fa),
        .SOFT_RESET_PULSE(sr));
    cfg_access_host cfg_access_host_i (.CLK_SYS(clk), .RESETN(rstn),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_READDATA(rdq), .AVS_WAITREQUEST(wq),
        .PAIR_HIGH(strap), .BUS(bus_if));
    cfg_port_checker cfg_port_checker_i (.CLK_SYS(clk), .RESETN(rstn),
        .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata),
        .io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd),
        .io_rdata(bus_if.io_rdata), .CONFIG_MODE(cfg), .FUNC_ACTIVE(fa));
    initial forever #25 clk = ~clk;
    // count one-cycle soft reset pulses
    always @(posedge clk) begin
        if (sr === 1'b1)
            pulses++;
    end
    task conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // straps held through reset, first request driven after the fifth edge after release
    task rst(input logic s);
        strap <= s;
        rstn <= 0;
        repeat (4) @(posedge clk);
        rstn <= 1;
        repeat (4) @(posedge clk);
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task av(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 100);
        if (wq !== 1'b0) begin
            mismatches++;
            conclude();
        end else begin
            q = rdq;
            rd <= 0;
            wr <= 0;
        end
    endtask
    task cmd(input logic [1:0] op, input logic [7:0] x, d);
        av(4'h0, 1'b1, {14'h0, op, x, d});
    endtask
    // read a register, then compare the status byte, busy clear
    task getc(input logic [7:0] x, e);
        cmd(2'h3, x, 8'h00);
        av(4'h4, 1'b0, 32'h0);
        `CHK(q[8:0], {1'b0, e})
    endtask
    initial begin
        rst(0);
        cmd(2'h0, 8'h00, 8'h00);
        @(negedge clk);
        `CHK(cfg, 1'b1)
        getc(8'h07, 8'h00);
        getc(8'h23, 8'hf0);
        getc(8'h24, 8'h40);
        getc(8'h26, 8'h00);
        for (i = 0; i < 16; i++) begin
            cmd(2'h2, 8'h07, i[7:0]);
            @(negedge clk);
            `CHK(fa, i == 4 ? 16'h0 : 16'h1 << i)
        end
        $display("reset values and function map done");
        cmd(2'h2, 8'h07, 8'h04);
        cmd(2'h2, 8'h30, 8'h77);
        getc(8'h30, 8'h00);
        cmd(2'h2, 8'h07, 8'h02);
        cmd(2'h2, 8'h30, 8'h5a);
        cmd(2'h2, 8'h07, 8'h03);
        cmd(2'h2, 8'h30, 8'ha5);
        cmd(2'h2, 8'h22, 8'h3c);
        getc(8'h22, 8'h3c);
        getc(8'h30, 8'ha5);
        cmd(2'h2, 8'h07, 8'h02);
        getc(8'h30, 8'h5a);
        cmd(2'h2, 8'h02, 8'h01);
        @(negedge clk);
        `CHK(pulses, 1)
        cmd(2'h1, 8'h00, 8'h00);
        @(negedge clk);
        `CHK(cfg, 1'b0)
        cmd(2'h2, 8'h22, 8'h00);
        getc(8'h22, 8'h00);
        cmd(2'h0, 8'h00, 8'h00);
        getc(8'h22, 8'h3c);
        av(4'h8, 1'b0, 32'h0);
        `CHK(q, 32'h0)
        $display("selection and lock done");
        rst(1);
        cmd(2'h0, 8'h00, 8'h00);
        getc(8'h26, 8'h40);
        getc(8'h24, 8'h46);
        $display("strapped port pair done");
        conclude();
    end
endmodule
